// ---- rtl/power_event_pkg.sv ----
// constants for the power event and reset cause block
package power_event_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] OFF_PF_WARN = 12'h108;
    localparam logic [11:0] OFF_SLEEP_ENTRY = 12'h114;
    localparam logic [11:0] OFF_SLEEP_EXIT = 12'h118;
    localparam logic [11:0] OFF_IRQ_SET = 12'h304;
    localparam logic [11:0] OFF_IRQ_CLR = 12'h308;
    localparam logic [11:0] OFF_RESET_CAUSE = 12'h400;
    localparam logic [11:0] OFF_PF_CONFIG = 12'h510;
    localparam logic [11:0] OFF_EVENT_STATUS = 12'h600;
    // event bit positions in enable and status registers
    localparam int EV_PF_WARN = 0;
    localparam int EV_SLEEP_ENTRY = 1;
    localparam int EV_SLEEP_EXIT = 2;
    localparam int NUM_EV = 3;
    // reset cause bit positions
    localparam int RC_PIN = 0;
    localparam int RC_WATCHDOG = 1;
    localparam int RC_SOFT = 2;
    localparam int RC_HANG = 3;
    localparam int RC_GPIO_WAKE = 4;
    localparam int RC_DEBUG_WAKE = 5;
    localparam int NUM_RC = 6;
    // comparator configuration fields
    localparam int PF_EN_BIT = 0;
    localparam int PF_THR_LSB = 1;
    localparam int PF_THR_W = 4;
    localparam logic [3:0] PF_THR_MIN = 4'h4;
    localparam logic [3:0] PF_THR_RESET = 4'h0;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

// ---- rtl/power_event_reset_cause.sv ----
// power event flags, interrupt enables and reset cause register
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
//
// Behaviour
// - power-fail warning flag at 0x108
// - sleep-entry flag set on sleep start
// - sleep-exit flag set on sleep end
// - enable-set writes one, reads enable state
// - enable-set also covers both sleep events
// - enable-clear writes one disables, reads state
// - reset causes accumulate until software clears
// - writing one clears only that cause
// - no cause set means power-on reset
// - pin reset sets pin cause flag
// - watchdog reset sets watchdog cause flag
// - software reset sets soft cause flag
// - processor hang sets hang cause flag
// - gpio wake from off sets flag
// - debug wake from off sets flag
// - comparator enable and threshold codes 4-15
module power_event_reset_cause (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic por_reset,
    input wire logic [power_event_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [power_event_pkg::DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [power_event_pkg::DATA_W-1:0] bus_rdata,
    input wire logic cpu_wait_sleep,
    input wire logic supply_low_async,
    input wire logic src_pin_reset,
    input wire logic src_watchdog,
    input wire logic src_soft_reset,
    input wire logic src_cpu_hang,
    input wire logic src_gpio_wake,
    input wire logic src_debug_wake,
    output logic power_fail_comparator_en,
    output logic [power_event_pkg::PF_THR_W-1:0] power_fail_threshold,
    output logic irq
);
    localparam int NE = power_event_pkg::NUM_EV;
    localparam int NR = power_event_pkg::NUM_RC;

    logic [NE-1:0] event_reg;
    logic [NE-1:0] event_next;
    logic [NE-1:0] enable_reg;
    logic [NR-1:0] cause_reg;
    logic [NR-1:0] cause_src;
    logic pf_en_reg;
    logic [power_event_pkg::PF_THR_W-1:0] pf_thr_reg;
    logic [2:0] low_sync_reg;
    logic low_state_reg;
    logic sleep_prev_reg;
    logic [power_event_pkg::DATA_W-1:0] rdata_reg;
    logic irq_reg;
    logic [NE-1:0] ev_hit;
    logic wr_pf, wr_entry, wr_exit, wr_set, wr_clr, wr_cause, wr_cfg;
    logic rd_status;

    assign wr_pf = bus_wr && bus_addr == power_event_pkg::OFF_PF_WARN;
    assign wr_entry = bus_wr && bus_addr == power_event_pkg::OFF_SLEEP_ENTRY;
    assign wr_exit = bus_wr && bus_addr == power_event_pkg::OFF_SLEEP_EXIT;
    assign wr_set = bus_wr && bus_addr == power_event_pkg::OFF_IRQ_SET;
    assign wr_clr = bus_wr && bus_addr == power_event_pkg::OFF_IRQ_CLR;
    assign wr_cause = bus_wr && bus_addr == power_event_pkg::OFF_RESET_CAUSE;
    assign wr_cfg = bus_wr && bus_addr == power_event_pkg::OFF_PF_CONFIG;
    assign rd_status = bus_rd && bus_addr == power_event_pkg::OFF_EVENT_STATUS;

    // supply-low input: three flops, change taken when stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            low_sync_reg <= 3'h0;
            low_state_reg <= 1'b0;
        end else begin
            low_sync_reg <= {low_sync_reg[1:0], supply_low_async};
            if (low_sync_reg[1] == low_sync_reg[2]) begin
                low_state_reg <= low_sync_reg[2];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sleep_prev_reg <= 1'b0;
        end else begin
            sleep_prev_reg <= cpu_wait_sleep;
        end
    end

    always_comb begin
        ev_hit = '0;
        ev_hit[power_event_pkg::EV_PF_WARN] = pf_en_reg && pf_thr_ok() && low_edge();
        ev_hit[power_event_pkg::EV_SLEEP_ENTRY] = cpu_wait_sleep && !sleep_prev_reg;
        ev_hit[power_event_pkg::EV_SLEEP_EXIT] = !cpu_wait_sleep && sleep_prev_reg;
    end

    function automatic logic pf_thr_ok();
        return pf_thr_reg >= power_event_pkg::PF_THR_MIN;
    endfunction

    logic low_prev_reg;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            low_prev_reg <= 1'b0;
        end else begin
            low_prev_reg <= low_state_reg;
        end
    end

    function automatic logic low_edge();
        return low_state_reg && !low_prev_reg;
    endfunction

    always_comb begin
        event_next = event_reg;
        if (wr_pf) begin
            event_next[power_event_pkg::EV_PF_WARN] = bus_wdata[0];
        end
        if (wr_entry) begin
            event_next[power_event_pkg::EV_SLEEP_ENTRY] = bus_wdata[0];
        end
        if (wr_exit) begin
            event_next[power_event_pkg::EV_SLEEP_EXIT] = bus_wdata[0];
        end
        if (rd_status) begin
            event_next = '0;
        end
        // hardware set wins over any clear
        event_next = event_next | ev_hit;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            event_reg <= '0;
        end else begin
            event_reg <= event_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            enable_reg <= '0;
        end else if (wr_set) begin
            enable_reg <= enable_reg | bus_wdata[NE-1:0];
        end else if (wr_clr) begin
            enable_reg <= enable_reg & ~bus_wdata[NE-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pf_en_reg <= 1'b0;
            pf_thr_reg <= power_event_pkg::PF_THR_RESET;
        end else if (wr_cfg) begin
            pf_en_reg <= bus_wdata[power_event_pkg::PF_EN_BIT];
            pf_thr_reg <= bus_wdata[power_event_pkg::PF_THR_LSB +: power_event_pkg::PF_THR_W];
        end
    end

    always_comb begin
        cause_src = '0;
        cause_src[power_event_pkg::RC_PIN] = src_pin_reset;
        cause_src[power_event_pkg::RC_WATCHDOG] = src_watchdog;
        cause_src[power_event_pkg::RC_SOFT] = src_soft_reset;
        cause_src[power_event_pkg::RC_HANG] = src_cpu_hang;
        cause_src[power_event_pkg::RC_GPIO_WAKE] = src_gpio_wake;
        cause_src[power_event_pkg::RC_DEBUG_WAKE] = src_debug_wake;
    end

    // cause flags survive the ordinary reset, which ORs the cause sources into them
    always_ff @(posedge clk_sys) begin
        if (por_reset) begin
            cause_reg <= '0;
        end else if (reset) begin
            cause_reg <= cause_reg | cause_src;
        end else if (wr_cause) begin
            cause_reg <= cause_reg & ~bus_wdata[NR-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_reg <= power_event_pkg::READ_ZERO;
        end else if (bus_rd) begin
            rdata_reg <= power_event_pkg::READ_ZERO;
            case (bus_addr)
                power_event_pkg::OFF_PF_WARN:
                    rdata_reg[0] <= event_reg[power_event_pkg::EV_PF_WARN];
                power_event_pkg::OFF_SLEEP_ENTRY:
                    rdata_reg[0] <= event_reg[power_event_pkg::EV_SLEEP_ENTRY];
                power_event_pkg::OFF_SLEEP_EXIT:
                    rdata_reg[0] <= event_reg[power_event_pkg::EV_SLEEP_EXIT];
                power_event_pkg::OFF_IRQ_SET, power_event_pkg::OFF_IRQ_CLR:
                    rdata_reg[NE-1:0] <= enable_reg;
                power_event_pkg::OFF_RESET_CAUSE:
                    rdata_reg[NR-1:0] <= cause_reg;
                power_event_pkg::OFF_PF_CONFIG: begin
                    rdata_reg[power_event_pkg::PF_EN_BIT] <= pf_en_reg;
                    rdata_reg[power_event_pkg::PF_THR_LSB +: power_event_pkg::PF_THR_W]
                        <= pf_thr_reg;
                end
                power_event_pkg::OFF_EVENT_STATUS:
                    rdata_reg[NE-1:0] <= event_reg;
                default:
                    rdata_reg <= power_event_pkg::READ_ZERO;
            endcase
        end else begin
            rdata_reg <= power_event_pkg::READ_ZERO;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_reg <= 1'b0;
        end else begin
            // level irq from flag and enable
            irq_reg <= |(event_reg & enable_reg);
        end
    end

    assign bus_rdata = rdata_reg;
    assign irq = irq_reg;
    assign power_fail_comparator_en = pf_en_reg;
    assign power_fail_threshold = pf_thr_reg;
endmodule // power_event_reset_cause

// ---- tb/power_event_checker_asserts.sv ----
// port assertions for the power event block
`timescale 1ns/1ns
module power_event_checker (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic por_reset,
    input wire logic [11:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [31:0] bus_rdata,
    input wire logic cpu_wait_sleep,
    input wire logic supply_low_async,
    input wire logic src_pin_reset,
    input wire logic src_watchdog,
    input wire logic src_soft_reset,
    input wire logic src_cpu_hang,
    input wire logic src_gpio_wake,
    input wire logic src_debug_wake,
    input wire logic power_fail_comparator_en,
    input wire logic [3:0] power_fail_threshold,
    input wire logic irq
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
        else $error("read data not idle");
    reset_quiet_a: assert property (disable iff (1'b0) reset |=>
        !irq && !power_fail_comparator_en && bus_rdata == 32'h0) else $error("not quiet");
    enable_set_a: assert property ((bus_wr && bus_addr == 12'h304 && bus_wdata[0])
        ##1 (bus_rd && bus_addr == 12'h304) |=> bus_rdata[0]) else $error("set lost");
    enable_clr_a: assert property ((bus_wr && bus_addr == 12'h308 && bus_wdata[0])
        ##1 (bus_rd && bus_addr == 12'h304) |=> !bus_rdata[0]) else $error("clear lost");
    entry_flag_a: assert property ($rose(cpu_wait_sleep)
        ##1 (bus_rd && bus_addr == 12'h114) |=> bus_rdata[0]) else $error("no entry flag");
    exit_flag_a: assert property ($fell(cpu_wait_sleep)
        ##1 (bus_rd && bus_addr == 12'h118) |=> bus_rdata[0]) else $error("no exit flag");
    irq_off_a: assert property ((bus_wr && bus_addr == 12'h308 && bus_wdata[2:0] == 3'h7)
        |-> ##2 !irq) else $error("irq with all enables off");
    cfg_load_a: assert property ((bus_wr && bus_addr == 12'h510 && bus_wdata[4:0] == 5'h09)
        |=> power_fail_comparator_en && power_fail_threshold == 4'h4) else $error("cfg");
endmodule // power_event_checker

bind power_event_reset_cause power_event_checker checker_u (.*);

// ---- tb/power_event_reset_cause_tb.sv ----
// self-checking bench for the power event block
`timescale 1ns/1ns
module power_event_reset_cause_tb;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic por_reset = 1'b1;
    logic [11:0] bus_addr = 12'h0;
    logic [31:0] bus_wdata = 32'h0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic sleep = 1'b0;
    logic low = 1'b0;
    logic [5:0] src = 6'h0;
    logic [31:0] bus_rdata;
    logic cmp_en;
    logic [3:0] thr;
    logic irq;
    logic [31:0] v;
    logic [5:0] acc;
    int err_total = 0;
    int checks = 0;
    // write flag, address, data byte
    logic [20:0] rows [16] = '{21'h030400, 21'h010800, 21'h011400, 21'h011800, 21'h130407,
        21'h030407, 21'h030807, 21'h130805, 21'h030402, 21'h130802, 21'h030800, 21'h00ff00,
        21'h110801, 21'h010801, 21'h110800, 21'h010800};
    power_event_reset_cause dut_u (.clk_sys(clk_sys), .reset(reset), .por_reset(por_reset),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .cpu_wait_sleep(sleep), .supply_low_async(low),
        .src_pin_reset(src[0]), .src_watchdog(src[1]), .src_soft_reset(src[2]),
        .src_cpu_hang(src[3]), .src_gpio_wake(src[4]), .src_debug_wake(src[5]),
        .power_fail_comparator_en(cmp_en), .power_fail_threshold(thr), .irq(irq));
    always #50 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask
    task automatic give_verdict();
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        err_total++;
        give_verdict();
    end
    initial begin
        tick(20);
        reset <= 1'b0;
        por_reset <= 1'b0;
        tick(1);
        rd(12'h400, v);
        chk(v, 32'h0);
        foreach (rows[i]) begin
            if (rows[i][20]) begin
                wr(rows[i][19:8], {24'h0, rows[i][7:0]});
            end else begin
                rd(rows[i][19:8], v);
                chk(v, {24'h0, rows[i][7:0]});
            end
        end
        sleep <= 1'b1;
        tick(1);
        rd(12'h114, v);
        chk(v, 32'h1);
        sleep <= 1'b0;
        tick(1);
        rd(12'h118, v);
        chk(v, 32'h1);
        wr(12'h304, 32'h4);
        tick(1);
        chk({31'h0, irq}, 32'h1);
        wr(12'h118, 32'h0);
        tick(1);
        chk({31'h0, irq}, 32'h0);
        wr(12'h308, 32'h7);
        wr(12'h510, 32'h9);
        chk({27'h0, cmp_en, thr}, 32'h14);
        low <= 1'b1;
        v = 32'h0;
        for (int i = 0; i < 10 && v !== 32'h1; i++) begin
            rd(12'h108, v);
        end
        chk(v, 32'h1);
        if (v !== 32'h1) begin
            give_verdict();
        end
        low <= 1'b0;
        wr(12'h510, 32'h7);
        wr(12'h108, 32'h0);
        tick(8);
        low <= 1'b1;
        tick(8);
        rd(12'h108, v);
        chk(v, 32'h0);
        wr(12'h304, 32'h7);
        acc = 6'h0;
        for (int i = 0; i < 6; i++) begin
            src <= 6'h1 << i;
            reset <= 1'b1;
            tick(2);
            src <= 6'h0;
            reset <= 1'b0;
            tick(1);
            acc[i] = 1'b1;
            rd(12'h400, v);
            chk(v, {26'h0, acc});
        end
        rd(12'h304, v);
        chk(v, 32'h0);
        wr(12'h400, 32'h4);
        rd(12'h400, v);
        chk(v, 32'h3b);
        sleep <= 1'b1;
        tick(1);
        rd(12'h600, v);
        chk(v, 32'h2);
        rd(12'h600, v);
        chk(v, 32'h0);
        give_verdict();
    end
endmodule // power_event_reset_cause_tb
